//--- aal1_ces_channel_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module aal1_ces_channel_config_tb
	import ces_pkg::*;
;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_tx_cell, i_tx_bd_ready, i_rx_cell, i_rx_has_sp;
	logic [7:0] i_tx_chan, i_rx_chan, i_rx_sp_octet, o_tx_sp_octet;
	logic [6:0] i_tx_offset, o_rx_sp_offset;
	logic [2:0] i_rx_sn;
	logic [31:0] o_rdata, o_tx_tmpl_addr, o_stat_addr;
	logic o_tx_valid, o_rx_sp_valid, o_filler_valid, o_stat_inc, o_entry_wr, o_irq;
	logic [15:0] o_filler_addr, o_entry_sn_word, o_entry_ptr_word;
	int errors = 0;
	int comparisons = 0;

	always #5 i_clock = ~i_clock;

	ces_channel dut_u (.i_clock, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_tx_cell, .i_tx_chan, .i_tx_bd_ready, .i_tx_offset, .o_tx_valid, .o_tx_sp_octet,
		.o_tx_tmpl_addr, .i_rx_cell, .i_rx_chan, .i_rx_sn, .i_rx_has_sp, .i_rx_sp_octet,
		.o_rx_sp_valid, .o_rx_sp_offset, .o_filler_valid, .o_filler_addr, .o_stat_inc,
		.o_stat_addr, .o_entry_wr, .o_entry_sn_word, .o_entry_ptr_word, .o_irq);

	ces_phy_model phy_u (.i_clock(i_clock), .o_tx_cell(i_tx_cell), .o_tx_chan(i_tx_chan),
		.o_tx_bd_ready(i_tx_bd_ready), .o_tx_offset(i_tx_offset), .o_rx_cell(i_rx_cell),
		.o_rx_chan(i_rx_chan), .o_rx_sn(i_rx_sn), .o_rx_has_sp(i_rx_has_sp),
		.o_rx_sp_octet(i_rx_sp_octet));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp, what);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge i_clock);
		i_rst_b <= 1'b1;
		rd(OFS_SNE, 32'h0, "count reset");
		wr(OFS_TX_TMPL, 32'h0001_0000);
		wr(OFS_ISTAT, 32'hFFFF_0100);
		wr(OFS_FILL, 32'hFFFF_0200);
		wr(OFS_XSTAT, 32'h0002_0000);
		rd(OFS_TX_TMPL, 32'h0001_0000, "tmpl base");
		rd(OFS_ISTAT, 32'h0000_0100, "istat base");
		rd(OFS_FILL, 32'h0000_0200, "filler base");
		rd(OFS_XSTAT, 32'h0002_0000, "xstat base");
		rd(8'h44, 32'h0, "unmapped");
		wr(OFS_MASK, 32'h0000_000F);
		// Block size 8, emulation type, structured, slip on; upper fields left zero.
		wr(OFS_CTRL, 32'h0008_001D);
		rd(OFS_CTRL, 32'h0008_001D, "ctrl");
		rd(OFS_MASK, 32'h0000_000F, "mask");
		phy_u.tx(8'h02, 7'h07, 1'b0);
		#1;
		chk(32'(o_tx_valid), 32'h1, "tx valid");
		chk(32'(o_tx_sp_octet), 32'h87, "tx octet");
		chk(o_tx_tmpl_addr, 32'h0001_0080, "tmpl addr");
		rd(OFS_STATUS, 32'h1, "busy");
		chk(32'(o_irq), 32'h1, "irq busy");
		wr(OFS_STATUS, 32'hF);
		rd(OFS_STATUS, 32'h0, "cleared");
		chk(32'(o_irq), 32'h0, "irq clear");
		phy_u.rx(8'h03, 3'h0, 7'h05, 1'b0);
		#1;
		chk(32'(o_rx_sp_valid), 32'h1, "sp valid");
		chk(32'(o_entry_wr), 32'h1, "entry wr");
		chk(32'(o_stat_inc), 32'h0, "first sn");
		phy_u.rx(8'h03, 3'h2, 7'h09, 1'b1);
		#1;
		chk(32'(o_rx_sp_valid), 32'h0, "bad sp");
		chk(32'(o_rx_sp_offset), 32'h5, "kept offset");
		chk(32'(o_filler_valid), 32'h1, "filler");
		chk(32'(o_filler_addr), 32'h0200, "filler addr");
		chk(32'(o_stat_inc), 32'h1, "stat inc");
		chk(o_stat_addr, 32'h0002_0030, "stat addr");
		chk(32'(o_entry_sn_word), 32'h0082, "sn word");
		chk(32'(o_entry_ptr_word), 32'h0005, "ptr word");
		rd(OFS_STATUS, 32'hE, "rx status");
		rd(OFS_SNE, 32'h1, "sne count");
		wr(OFS_MASK, 32'h0);
		rd(OFS_STATUS, 32'hE, "masked");
		chk(32'(o_irq), 32'h0, "irq masked");
		wr(OFS_STATUS, 32'hF);
		// Plain structured type with the slip mask cleared: no parity check, no slip.
		wr(OFS_CTRL, 32'h0008_0009);
		phy_u.rx(8'h03, 3'h4, 7'h09, 1'b1);
		#1;
		chk(32'(o_rx_sp_valid), 32'h1, "plain sp");
		chk(32'(o_filler_valid), 32'h1, "plain drop");
		rd(OFS_STATUS, 32'h4, "no slip");
		phy_u.tx(8'h01, 7'h07, 1'b1);
		#1;
		chk(32'(o_tx_sp_octet), 32'h07, "plain octet");
		// The sequence error bit of the last cell is still set; busy must stay clear.
		rd(OFS_STATUS, 32'h4, "ready tx");
		// A gap of two counts is a sequence error, but not a single lost cell.
		phy_u.rx(8'h03, 3'h7, 7'h01, 1'b0);
		#1;
		chk(32'(o_stat_inc), 32'h1, "gap stat");
		chk(32'(o_filler_valid), 32'h0, "gap no filler");
		chk(32'(o_rx_sp_offset), 32'h1, "plain offset");
		rd(OFS_SNE, 32'h3, "sne gap");
		wr(OFS_CTRL, 32'h0008_0005);
		phy_u.tx(8'h01, 7'h07, 1'b1);
		#1;
		chk(32'(o_tx_sp_octet), 32'h00, "unstructured");
		give_verdict();
	end
endmodule // aal1_ces_channel_config_tb
`default_nettype wire

//--- ces_channel.sv
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ces_channel
	import ces_pkg::*;
(
	input wire logic i_clock, // 100 MHz clock
	input wire logic i_rst_b, // async reset, low
	input wire logic [7:0] i_addr, // register offset
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [31:0] o_rdata, // read data, next cycle
	input wire logic i_tx_cell, // transmit cell start
	input wire logic [7:0] i_tx_chan, // transmit channel
	input wire logic i_tx_bd_ready, // next descriptor ready
	input wire logic [6:0] i_tx_offset, // structure offset
	output logic o_tx_valid, // pointer octet valid
	output logic [7:0] o_tx_sp_octet, // pointer octet
	output logic [31:0] o_tx_tmpl_addr, // cell template address
	input wire logic i_rx_cell, // received cell pulse
	input wire logic [7:0] i_rx_chan, // receive channel
	input wire logic [2:0] i_rx_sn, // received sequence count
	input wire logic i_rx_has_sp, // cell carries pointer
	input wire logic [7:0] i_rx_sp_octet, // received pointer octet
	output logic o_rx_sp_valid, // last pointer usable
	output logic [6:0] o_rx_sp_offset, // last good offset
	output logic o_filler_valid, // insert filler cell
	output logic [15:0] o_filler_addr, // filler cell address
	output logic o_stat_inc, // bump error statistic
	output logic [31:0] o_stat_addr, // statistics record
	output logic o_entry_wr, // entry words update
	output logic [15:0] o_entry_sn_word, // word at 0x16
	output logic [15:0] o_entry_ptr_word, // word at 0x12
	output logic o_irq // interrupt, high level
);
	typedef struct packed {
		logic [31:0] tx_base;
		logic [15:0] istat_base;
		logic [15:0] fill_base;
		logic [31:0] xstat_base;
		logic [31:0] ctrl;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [15:0] sne_cnt;
		logic [31:0] rdata;
		logic tx_valid;
		logic [7:0] tx_sp;
		logic [31:0] tx_tmpl;
		logic sp_valid;
		logic [6:0] sp_off;
		logic fill_valid;
		logic [15:0] fill_addr;
		logic stat_inc;
		logic [31:0] stat_addr;
		logic entry_wr;
		logic [15:0] entry_sn;
		logic [15:0] entry_ptr;
		logic irq;
	} ces_chan_s;

	ces_chan_s st;
	ces_chan_s next_st;
	logic seq_err;
	logic seq_drop;
	logic [2:0] ctype;
	logic is_ces;
	logic structured;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;
	logic rx_par_ok;

	ces_seq_track u_seq (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_cell(i_rx_cell),
		.i_sn(i_rx_sn),
		.o_err(seq_err),
		.o_drop(seq_drop)
	);

	always_comb
	begin
		next_st = st;
		ev = '0;
		clr = '0;
		ctype = st.ctrl[CTRL_TYPE_LSB +: 3];
		is_ces = (ctype == TYPE_CES);
		structured = st.ctrl[CTRL_STF_BIT] && ces_is_aal1(ctype);
		rx_par_ok = (i_rx_sp_octet[7] == ces_sp_parity(i_rx_sp_octet[6:0]));
		next_st.rdata = '0;
		next_st.tx_valid = 1'b0;
		next_st.fill_valid = 1'b0;
		next_st.stat_inc = 1'b0;
		next_st.entry_wr = 1'b0;

		if (i_wr)
		begin
			case (i_addr)
				OFS_TX_TMPL: next_st.tx_base = i_wdata;
				OFS_ISTAT: next_st.istat_base = i_wdata[15:0];
				OFS_FILL: next_st.fill_base = i_wdata[15:0];
				OFS_XSTAT: next_st.xstat_base = i_wdata;
				OFS_CTRL: next_st.ctrl = i_wdata & CTRL_WMASK;
				OFS_STATUS: clr = i_wdata[EV_W-1:0];
				OFS_MASK: next_st.mask = i_wdata[EV_W-1:0];
				default: clr = '0;
			endcase
		end
		if (i_rd)
		begin
			case (i_addr)
				OFS_TX_TMPL: next_st.rdata = st.tx_base;
				OFS_ISTAT: next_st.rdata = {16'h0000, st.istat_base};
				OFS_FILL: next_st.rdata = {16'h0000, st.fill_base};
				OFS_XSTAT: next_st.rdata = st.xstat_base;
				OFS_CTRL: next_st.rdata = st.ctrl;
				OFS_STATUS: next_st.rdata = {28'h0000000, st.status};
				OFS_MASK: next_st.rdata = {28'h0000000, st.mask};
				OFS_SNE: next_st.rdata = {16'h0000, st.sne_cnt};
				default: next_st.rdata = '0;
			endcase
		end

		// transmit path shared by both types
		if (i_tx_cell)
		begin
			next_st.tx_valid = 1'b1;
			next_st.tx_tmpl = st.tx_base + 32'({24'h000000, i_tx_chan} << TMPL_SHIFT);
			// parity generated only in emulation mode
			if (structured && is_ces)
				next_st.tx_sp = {ces_sp_parity(i_tx_offset), i_tx_offset};
			else if (structured)
				next_st.tx_sp = {1'b0, i_tx_offset};
			else
				next_st.tx_sp = 8'h00;
			// busy only flags; the octet above is untouched
			if (!i_tx_bd_ready)
				ev[EV_TX_BUSY] = 1'b1;
		end

		if (i_rx_cell)
		begin
			if (structured && i_rx_has_sp)
			begin
				// a failed pointer keeps the last good offset
				if (is_ces && !rx_par_ok)
				begin
					next_st.sp_valid = 1'b0;
					ev[EV_SP_PAR] = 1'b1;
				end
				else
				begin
					next_st.sp_valid = 1'b1;
					next_st.sp_off = i_rx_sp_octet[6:0];
				end
			end
			if (seq_err)
			begin
				ev[EV_SEQ] = 1'b1;
				next_st.stat_inc = 1'b1;
				next_st.sne_cnt = st.sne_cnt + 16'h0001;
				next_st.stat_addr = st.xstat_base +
					32'({24'h000000, i_rx_chan} << XSTAT_SHIFT);
			end
			// one lost cell is replaced by the filler
			if (seq_drop)
			begin
				next_st.fill_valid = 1'b1;
				next_st.fill_addr = st.fill_base;
				// slip event only while mask bit set
				if (st.ctrl[CTRL_SLIP_BIT])
					ev[EV_SLIP] = 1'b1;
			end
			next_st.entry_wr = 1'b1;
			next_st.entry_sn = {st.ctrl[CTRL_BLK_LSB +: BLK_W], 1'b0, i_rx_sn};
			next_st.entry_ptr = {next_st.sp_valid, 8'h00, next_st.sp_off};
		end

		// A new event wins over a clear in the same cycle.
		next_st.status = (st.status & ~clr) | ev;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_rdata = st.rdata;
	assign o_tx_valid = st.tx_valid;
	assign o_tx_sp_octet = st.tx_sp;
	assign o_tx_tmpl_addr = st.tx_tmpl;
	assign o_rx_sp_valid = st.sp_valid;
	assign o_rx_sp_offset = st.sp_off;
	assign o_filler_valid = st.fill_valid;
	assign o_filler_addr = st.fill_addr;
	assign o_stat_inc = st.stat_inc;
	assign o_stat_addr = st.stat_addr;
	assign o_entry_wr = st.entry_wr;
	assign o_entry_sn_word = st.entry_sn;
	assign o_entry_ptr_word = st.entry_ptr;
	assign o_irq = st.irq;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);

	// Transmit side: pointer octet, template address and busy event.
	a_tx_parity_gen: assert property (i_tx_cell && structured && is_ces
		|=> o_tx_valid && !(^o_tx_sp_octet))
		else $error("tx pointer parity wrong");
	a_plain_no_parity: assert property (i_tx_cell && structured && !is_ces
		|=> o_tx_sp_octet == {1'b0, $past(i_tx_offset)})
		else $error("plain pointer altered");
	a_unstruct_zero: assert property (i_tx_cell && !structured
		|=> o_tx_sp_octet == 8'h00)
		else $error("unstructured cell got a pointer");
	a_tx_valid_pulse: assert property (!i_tx_cell
		|=> !o_tx_valid)
		else $error("tx valid without a cell");
	a_tmpl_addr: assert property (i_tx_cell
		|=> o_tx_tmpl_addr == $past(st.tx_base) + {18'h00000, $past(i_tx_chan), 6'h00})
		else $error("template address wrong");
	a_busy_sets_flag: assert property (i_tx_cell && !i_tx_bd_ready
		|=> st.status[EV_TX_BUSY])
		else $error("busy event lost");
	a_busy_sp_intact: assert property (i_tx_cell && !i_tx_bd_ready && structured
		|=> o_tx_sp_octet[6:0] == $past(i_tx_offset))
		else $error("busy corrupted pointer");

	// Receive side: pointer use, sequence statistics, filler and entry words.
	a_bad_sp_dropped: assert property (i_rx_cell && i_rx_has_sp && structured && is_ces
		&& !rx_par_ok |=> !o_rx_sp_valid && $stable(o_rx_sp_offset) && st.status[EV_SP_PAR])
		else $error("bad pointer used");
	a_good_sp_used: assert property (i_rx_cell && i_rx_has_sp && structured
		&& (!is_ces || rx_par_ok) |=> o_rx_sp_valid && o_rx_sp_offset == $past(i_rx_sp_octet[6:0]))
		else $error("good pointer not taken");
	a_seq_err_stat: assert property (i_rx_cell && seq_err
		|=> o_stat_inc && (st.sne_cnt == $past(st.sne_cnt) + 16'h0001))
		else $error("sequence error not counted");
	a_stat_addr: assert property (i_rx_cell && seq_err
		|=> o_stat_addr == $past(st.xstat_base) + {20'h00000, $past(i_rx_chan), 4'h0})
		else $error("statistics address wrong");
	a_no_false_stat: assert property (!(i_rx_cell && seq_err)
		|=> !o_stat_inc)
		else $error("statistic bumped without error");
	a_sne_hold: assert property (!(i_rx_cell && seq_err)
		|=> $stable(st.sne_cnt))
		else $error("error count moved without error");
	a_filler_insert: assert property (i_rx_cell && seq_drop
		|=> o_filler_valid && (o_filler_addr == $past(st.fill_base)))
		else $error("filler not inserted");
	a_no_false_fill: assert property (!(i_rx_cell && seq_drop)
		|=> !o_filler_valid)
		else $error("filler without a dropped cell");
	a_slip_masked: assert property ($rose(st.status[EV_SLIP])
		|-> $past(st.ctrl[CTRL_SLIP_BIT]))
		else $error("slip raised while masked");
	a_slip_needs_drop: assert property ($rose(st.status[EV_SLIP])
		|-> $past(i_rx_cell && seq_drop))
		else $error("slip raised without a dropped cell");
	a_entry_sn: assert property (i_rx_cell
		|=> o_entry_wr && o_entry_sn_word[2:0] == $past(i_rx_sn))
		else $error("entry sequence word wrong");
	a_block_size: assert property (i_rx_cell
		|=> o_entry_sn_word[15:4] == $past(st.ctrl[CTRL_BLK_LSB +: BLK_W]))
		else $error("entry block size wrong");
	a_entry_ptr: assert property (i_rx_cell
		|=> o_entry_ptr_word == {o_rx_sp_valid, 8'h00, o_rx_sp_offset})
		else $error("entry pointer word wrong");

	// Register side: control, base pointers, status and interrupt.
	a_ctrl_mask: assert property (i_wr && (i_addr == OFS_CTRL)
		|=> st.ctrl == ($past(i_wdata) & CTRL_WMASK))
		else $error("control write wrong");
	a_istat_read: assert property (i_rd && (i_addr == OFS_ISTAT)
		|=> o_rdata == {16'h0000, $past(st.istat_base)})
		else $error("internal statistics base read wrong");
	a_xstat_read: assert property (i_rd && (i_addr == OFS_XSTAT)
		|=> o_rdata == $past(st.xstat_base))
		else $error("external statistics base read wrong");
	a_status_clear: assert property (i_wr && (i_addr == OFS_STATUS) && !i_tx_cell && !i_rx_cell
		|=> (st.status & $past(i_wdata[EV_W-1:0])) == '0)
		else $error("status bit not cleared");
	a_irq_level: assert property (o_irq == |(st.status & st.mask))
		else $error("interrupt level mismatch");

	c_ces_tx: cover property (i_tx_cell && structured && is_ces ##1 o_tx_valid);
	c_parity_fail: cover property (i_rx_cell && i_rx_has_sp && is_ces && !rx_par_ok);
	c_drop_fill: cover property (o_filler_valid ##[1:20] o_irq);
	c_busy_irq: cover property (st.status[EV_TX_BUSY] && o_irq);
	c_seq_gap: cover property (i_rx_cell && seq_err && !seq_drop ##1 o_stat_inc);
endmodule // ces_channel
`default_nettype wire

//--- ces_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module ces_phy_model (
	input wire logic i_clock, // system clock
	output logic o_tx_cell, // transmit cell start
	output logic [7:0] o_tx_chan, // transmit channel
	output logic o_tx_bd_ready, // descriptor ready
	output logic [6:0] o_tx_offset, // structure offset
	output logic o_rx_cell, // received cell pulse
	output logic [7:0] o_rx_chan, // receive channel
	output logic [2:0] o_rx_sn, // sequence count
	output logic o_rx_has_sp, // pointer present
	output logic [7:0] o_rx_sp_octet // pointer octet
);
	initial
	begin
		o_tx_cell = 1'b0;
		o_tx_chan = 8'h00;
		o_tx_bd_ready = 1'b0;
		o_tx_offset = 7'h00;
		o_rx_cell = 1'b0;
		o_rx_chan = 8'h00;
		o_rx_sn = 3'h0;
		o_rx_has_sp = 1'b0;
		o_rx_sp_octet = 8'h00;
	end

	// Fields are inverted after each cell so that stale values never pass for valid ones.
	task automatic tx(input logic [7:0] ch, input logic [6:0] off, input logic rdy);
		@(posedge i_clock);
		o_tx_cell <= 1'b1;
		o_tx_chan <= ch;
		o_tx_offset <= off;
		o_tx_bd_ready <= rdy;
		@(posedge i_clock);
		o_tx_cell <= 1'b0;
		o_tx_chan <= ~ch;
		o_tx_offset <= ~off;
		o_tx_bd_ready <= ~rdy;
	endtask

	task automatic rx(input logic [7:0] ch, input logic [2:0] sn, input logic [6:0] off,
		input logic bad);
		@(posedge i_clock);
		o_rx_cell <= 1'b1;
		o_rx_chan <= ch;
		o_rx_sn <= sn;
		o_rx_has_sp <= 1'b1;
		o_rx_sp_octet <= {(^off) ^ bad, off};
		@(posedge i_clock);
		o_rx_cell <= 1'b0;
		o_rx_chan <= ~ch;
		o_rx_sn <= ~sn;
		o_rx_has_sp <= 1'b0;
		o_rx_sp_octet <= ~o_rx_sp_octet;
	endtask
endmodule // ces_phy_model
`default_nettype wire

//--- ces_pkg.sv
// What this block does
// - Channel type 001 plain, 101 emulation
// - Structured AAL1 cells carry a pointer octet
// - Emulation mode generates and checks pointer parity
// - Descriptor not ready raises busy, pointer intact
// - Sequence errors counted into channel statistics
// - Filler base at 0xEA; insert on drop
// - Slip mask zero suppresses slip interrupts
// - Transmit entry layout unchanged for emulation
// - Emulation receive entry fields 0x0E to 0x18
package ces_pkg;
	localparam logic [2:0] TYPE_AAL1 = 3'h1;
	localparam logic [2:0] TYPE_CES = 3'h5;
	localparam logic [7:0] OFS_TX_TMPL = 8'hE0;
	localparam logic [7:0] OFS_ISTAT = 8'hE8;
	localparam logic [7:0] OFS_FILL = 8'hEA;
	localparam logic [7:0] OFS_XSTAT = 8'hF0;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_SNE = 8'h0C;
	localparam int CTRL_TYPE_LSB = 0;
	localparam int CTRL_STF_BIT = 3;
	localparam int CTRL_SLIP_BIT = 4;
	localparam int CTRL_BLK_LSB = 16;
	localparam int BLK_W = 12;
	localparam logic [31:0] CTRL_WMASK = 32'h0FFF_001F;
	localparam int EV_TX_BUSY = 0;
	localparam int EV_SP_PAR = 1;
	localparam int EV_SEQ = 2;
	localparam int EV_SLIP = 3;
	localparam int EV_W = 4;
	localparam int SN_W = 3;
	localparam int TMPL_SHIFT = 6;
	localparam int XSTAT_SHIFT = 4;
	// transmit entry area shared by both types
	localparam logic [7:0] TX_ENTRY_PS_OFS = 8'h0E;
	// receive entry word offsets and positions
	localparam logic [7:0] RX_FLAGS_OFS = 8'h0E;
	localparam logic [7:0] RX_PTR_OFS = 8'h12;
	localparam logic [7:0] RX_BDCNT_OFS = 8'h14;
	localparam logic [7:0] RX_SN_OFS = 8'h16;
	localparam logic [7:0] RX_SUPER_OFS = 8'h18;
	localparam int RX_SPV_POS = 15;
	localparam int RX_BLK_POS = 4;

	// Even parity: the top bit makes the octet's XOR zero.
	function automatic logic ces_sp_parity(input logic [6:0] off);
		return ^off;
	endfunction

	// both AAL1 type codes take structured pointers
	function automatic logic ces_is_aal1(input logic [2:0] t);
		return (t == TYPE_AAL1) || (t == TYPE_CES);
	endfunction
endpackage

//--- ces_seq_track.sv
`timescale 1ns/100ps
`default_nettype none
module ces_seq_track
	import ces_pkg::*;
(
	input wire logic i_clock, // system clock
	input wire logic i_rst_b, // async reset, low
	input wire logic i_cell, // received cell pulse
	input wire logic [SN_W-1:0] i_sn, // cell sequence count
	output logic o_err, // sequence mismatch
	output logic o_drop // exactly one cell missing
);
	typedef struct packed {
		logic synced;
		logic [SN_W-1:0] expected;
	} ces_seq_s;
	ces_seq_s st;
	ces_seq_s next_st;
	logic [SN_W-1:0] skip_one;

	// The first cell after reset only primes the tracker.
	always_comb
	begin
		next_st = st;
		skip_one = st.expected + 3'h1;
		o_err = i_cell && st.synced && (i_sn != st.expected);
		o_drop = o_err && (i_sn == skip_one);
		if (i_cell)
		begin
			next_st.synced = 1'b1;
			next_st.expected = i_sn + 3'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st <= '0;
		else
			st <= next_st;
	end
endmodule // ces_seq_track
`default_nettype wire
